// ---- pll_consts.svh ----
// Purpose: Field positions, codes and counts for the synthesizer latch bank
// Assumes: 24-bit serial words, MSB first
// Notes:   Included by the latch bank, the serial front end and the bench
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

`define PLL_WORD_W        24
`define PLL_SEL_CFG       2'h0
`define PLL_SEL_REF       2'h1
`define PLL_SEL_FB        2'h2
// Configuration word fields
`define PLL_CFG_PRESC_HI  23
`define PLL_CFG_PRESC_LO  22
`define PLL_CFG_PD_MODE   21
`define PLL_CFG_PD_EN     20
`define PLL_CFG_MUTE      11
`define PLL_CFG_GAIN      10
`define PLL_CFG_HIZ       9
`define PLL_CFG_POL       8
`define PLL_CFG_CLEAR     4
// Reference-divider word fields
`define PLL_REF_BAND_HI   21
`define PLL_REF_BAND_LO   20
`define PLL_REF_TEST      19
`define PLL_REF_PREC      18
`define PLL_REF_RATIO_HI  15
`define PLL_REF_RATIO_LO  2
// Feedback-divider word fields
`define PLL_FB_SOURCE     23
`define PLL_FB_HALVE      22
`define PLL_FB_GAIN       21
`define PLL_FB_MAIN_HI    20
`define PLL_FB_MAIN_LO    8
`define PLL_FB_SWAL_HI    6
`define PLL_FB_SWAL_LO    2
// Modulus values
`define PLL_MOD_8         6'h08
`define PLL_MOD_16        6'h10
`define PLL_MOD_32        6'h20
// Counts
`define PLL_SYNC_EDGES    2'h2
`define PLL_BAND_CYCLES   3'h5
`define PLL_LOCK_FINE     3'h5
`define PLL_LOCK_COARSE   3'h3
// Reset values
`define PLL_RATIO_RST     14'h0001
`define PLL_MAIN_RST      13'h0003

`endif

// ---- pll_div_counter.sv ----
// Purpose: Programmable tick divider, one pulse per ratio input ticks
// Assumes: Ratio of zero behaves as one
// Notes:   Hold keeps the count in its load state
`timescale 1ns/1ps
module pll_div_counter (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        tick,
    input  wire logic        hold,
    input  wire logic [13:0] ratio,
    output logic             out_q
);
    logic [13:0] cnt_q;
    logic [13:0] cnt_inc;

    assign cnt_inc = cnt_q + 14'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Count input ticks, pulse and reload at the ratio
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else if (clk_en) begin
            out_q <= 1'b0;
            if (hold) begin
                cnt_q <= '0;
            end else if (tick) begin
                if (cnt_inc >= ratio) begin
                    cnt_q <= '0;
                    out_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_inc;
                end
            end
        end
    end
endmodule

// ---- pll_host_model.sv ----
// Purpose: Host side of the three-wire serial bus
// Assumes: Bench calls send_word from one thread
// Notes:   Clock idles low; data idles at inverse of last bit
`timescale 1ns/1ps
module pll_host_model (
    input  wire logic mclk,
    output logic      sclk,
    output logic      sdata,
    output logic      load_enable
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_enable = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // One word, top bit first, then a one-cycle load pulse
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(posedge mclk) #1;
            sclk = 1'b0;
            sdata = w[i];
            @(posedge mclk) #1;
            sclk = 1'b1;
        end
        @(posedge mclk) #1;
        sclk = 1'b0;
        sdata = ~w[0]; // Released line shows no stale bit
        load_enable = 1'b1;
        @(posedge mclk) #1;
        load_enable = 1'b0;
    endtask
endmodule

// ---- pll_latch_programming.sv ----
// Purpose: Latch bank of an integer-N synthesizer with power-down control
// Assumes: All pins synchronous to mclk; ref_tick/fb_tick are one-cycle pulses
// Notes:   Analog paths appear only as control outputs
`timescale 1ns/1ps
`include "pll_consts.svh"
module pll_latch_programming
    import pll_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        sclk,
    input  wire logic        sdata,
    input  wire logic        load_enable,
    input  wire logic        chip_enable,
    input  wire logic        ref_tick,
    input  wire logic        fb_tick,
    input  wire logic        phase_small,
    input  wire logic        phase_large,
    output logic             power_down_q,
    output logic             pump_hiz_q,
    output logic             pump_gain_select_q,
    output logic             detector_polarity_q,
    output logic             ref_buf_en_q,
    output logic             rf_bias_q,
    output logic             lock_q,
    output logic             vtune_hold_q,
    output logic [5:0]       prescaler_mod_q,
    output logic             output_halving_q,
    output logic             prescaler_source_q,
    output logic [13:0]      ref_ratio_q,
    output logic [4:0]       swallow_count_q,
    output logic [12:0]      main_count_q,
    output logic             ref_div_out_q,
    output logic             fb_div_out_q,
    output logic             band_clk_q
);
    logic [`PLL_WORD_W-1:0] word;
    logic                   word_valid;
    logic                   wr_cfg;
    logic                   wr_ref;
    logic                   wr_fb;
    logic                   pd_en_q;
    logic                   pd_mode_q;
    logic                   mute_q;
    logic                   three_state_q;
    logic                   counter_clear_q;
    logic                   lock_precision_q;
    logic [1:0]             band_div_q;
    pll_pd_e                pd_state_q;
    logic [1:0]             ref_edges_q;
    logic                   pd_d;
    logic                   ctr_hold;
    logic [13:0]            band_ratio;
    logic                   band_tick;
    logic [2:0]             band_cnt_q;
    logic [2:0]             ok_cnt_q;
    logic [2:0]             lock_need;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler code to modulus value
    function automatic logic [5:0] modulus_of(input logic [1:0] code);
        begin
            case (code)
                2'b00:   modulus_of = `PLL_MOD_8;
                2'b01:   modulus_of = `PLL_MOD_16;
                default: modulus_of = `PLL_MOD_32;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial front end, independent of power state
    pll_serial_in u_serial (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .clk_en       (clk_en),
        .sclk         (sclk),
        .sdata        (sdata),
        .load_enable  (load_enable),
        .word_q       (word),
        .word_valid_q (word_valid)
    );

    // Latch routing; code 11 targets the test latch and is dropped
    assign wr_cfg = word_valid && (word[1:0] == `PLL_SEL_CFG);
    assign wr_ref = word_valid && (word[1:0] == `PLL_SEL_REF);
    assign wr_fb  = word_valid && (word[1:0] == `PLL_SEL_FB);

    ////////////////////////////////////////////////////////////////////////
    // Configuration latch
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prescaler_mod_q     <= `PLL_MOD_8;
            pd_en_q             <= 1'b0;
            pd_mode_q           <= 1'b0;
            mute_q              <= 1'b0;
            three_state_q       <= 1'b0;
            detector_polarity_q <= 1'b0;
            counter_clear_q     <= 1'b0;
        end else if (clk_en && wr_cfg) begin
            prescaler_mod_q     <= modulus_of(word[`PLL_CFG_PRESC_HI:`PLL_CFG_PRESC_LO]);
            pd_en_q             <= word[`PLL_CFG_PD_EN];
            pd_mode_q           <= word[`PLL_CFG_PD_MODE];
            mute_q              <= word[`PLL_CFG_MUTE];
            three_state_q       <= word[`PLL_CFG_HIZ];
            detector_polarity_q <= word[`PLL_CFG_POL];
            counter_clear_q     <= word[`PLL_CFG_CLEAR];
        end
    end

    // Gain bit shared by two latches, last write wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pump_gain_select_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_cfg) begin
                pump_gain_select_q <= word[`PLL_CFG_GAIN];
            end else if (wr_fb) begin
                pump_gain_select_q <= word[`PLL_FB_GAIN];
            end
        end
    end

    // Reference-divider latch; spare bits are not stored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ref_ratio_q      <= `PLL_RATIO_RST;
            lock_precision_q <= 1'b0;
            band_div_q       <= 2'h0;
        end else if (clk_en && wr_ref) begin
            ref_ratio_q      <= word[`PLL_REF_RATIO_HI:`PLL_REF_RATIO_LO];
            lock_precision_q <= word[`PLL_REF_PREC];
            band_div_q       <= word[`PLL_REF_BAND_HI:`PLL_REF_BAND_LO];
        end
    end

    // Feedback-divider latch
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            output_halving_q   <= 1'b0;
            prescaler_source_q <= 1'b0;
            swallow_count_q    <= '0;
            main_count_q       <= `PLL_MAIN_RST;
        end else if (clk_en && wr_fb) begin
            output_halving_q   <= word[`PLL_FB_HALVE];
            prescaler_source_q <= word[`PLL_FB_SOURCE];
            swallow_count_q    <= word[`PLL_FB_SWAL_HI:`PLL_FB_SWAL_LO];
            main_count_q       <= word[`PLL_FB_MAIN_HI:`PLL_FB_MAIN_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronous power-down waits for reference edges so the pump is quiet
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pd_state_q  <= PLL_PD_RUN;
            ref_edges_q <= 2'h0;
        end else if (clk_en) begin
            case (pd_state_q)
                PLL_PD_RUN: begin
                    ref_edges_q <= 2'h0;
                    if (wr_cfg && word[`PLL_CFG_PD_EN] && word[`PLL_CFG_PD_MODE]) begin
                        pd_state_q <= PLL_PD_WAIT;
                    end
                end
                PLL_PD_WAIT: begin
                    if (!pd_en_q || !pd_mode_q) begin
                        pd_state_q <= PLL_PD_RUN;
                    end else if (ref_div_out_q) begin
                        ref_edges_q <= ref_edges_q + 2'h1;
                        if (ref_edges_q + 2'h1 == `PLL_SYNC_EDGES) begin
                            pd_state_q <= PLL_PD_DOWN;
                        end
                    end
                end
                PLL_PD_DOWN: begin
                    if (!pd_en_q || !pd_mode_q) begin
                        pd_state_q <= PLL_PD_RUN;
                    end
                end
                default: pd_state_q <= PLL_PD_RUN;
            endcase
        end
    end

    // Any source of power-down
    always_comb begin
        pd_d = !chip_enable
             || (pd_en_q && !pd_mode_q)
             || (pd_state_q == PLL_PD_DOWN);
    end

    // Power-down side effects registered together with the flag
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            power_down_q <= 1'b1;
            pump_hiz_q   <= 1'b1;
            ref_buf_en_q <= 1'b0;
            rf_bias_q    <= 1'b0;
        end else if (clk_en) begin
            power_down_q <= pd_d;
            pump_hiz_q   <= pd_d || three_state_q;
            ref_buf_en_q <= !pd_d;
            rf_bias_q    <= !pd_d && (!mute_q || lock_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference and feedback counters, held at load state when asked
    assign ctr_hold = power_down_q || counter_clear_q;

    pll_div_counter u_ref_ctr (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .clk_en (clk_en),
        .tick   (ref_tick),
        .hold   (ctr_hold),
        .ratio  (ref_ratio_q),
        .out_q  (ref_div_out_q)
    );

    // Feedback count limited to the main count; swallow handled in the prescaler
    pll_div_counter u_fb_ctr (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .clk_en (clk_en),
        .tick   (fb_tick),
        .hold   (ctr_hold),
        .ratio  ({1'b0, main_count_q}),
        .out_q  (fb_div_out_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Band-select clock: reference output divided by 1, 2, 4 or 8
    assign band_ratio = 14'h0001 << band_div_q;

    pll_div_counter u_band_div (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .clk_en (clk_en),
        .tick   (ref_div_out_q),
        .hold   (power_down_q),
        .ratio  (band_ratio),
        .out_q  (band_tick)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            band_clk_q <= 1'b0;
        end else if (clk_en) begin
            band_clk_q <= band_tick;
        end
    end

    // Band selection window after each feedback write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            band_cnt_q   <= 3'h0;
            vtune_hold_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_fb) begin
                band_cnt_q   <= `PLL_BAND_CYCLES;
                vtune_hold_q <= 1'b1;
            end else if (band_tick && band_cnt_q != 3'h0) begin
                band_cnt_q   <= band_cnt_q - 3'h1;
                vtune_hold_q <= (band_cnt_q != 3'h1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital lock detect on each phase-detector cycle
    assign lock_need = lock_precision_q ? `PLL_LOCK_FINE : `PLL_LOCK_COARSE;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ok_cnt_q <= 3'h0;
            lock_q   <= 1'b0;
        end else if (clk_en) begin
            if (power_down_q) begin
                ok_cnt_q <= 3'h0;
                lock_q   <= 1'b0;
            end else if (ref_div_out_q) begin
                if (phase_large) begin
                    ok_cnt_q <= 3'h0;
                    lock_q   <= 1'b0;
                end else if (phase_small) begin
                    if (ok_cnt_q + 3'h1 >= lock_need) begin
                        lock_q <= 1'b1;
                    end
                    if (ok_cnt_q < `PLL_LOCK_FINE) begin
                        ok_cnt_q <= ok_cnt_q + 3'h1;
                    end
                end else if (!lock_q) begin
                    ok_cnt_q <= 3'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ref_route_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        wr_ref |=> ref_ratio_q == $past(word[15:2]))
        else $error("reference word not routed");

    presc_map_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        wr_cfg && word[23] |=> prescaler_mod_q == 6'h20)
        else $error("prescaler 32/33 not selected");

    async_pd_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        wr_cfg && word[20] && !word[21] |=> ##1 power_down_q)
        else $error("async power-down late");

    sync_pd_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        pd_state_q == PLL_PD_WAIT && pd_en_q && pd_mode_q && ref_edges_q == 2'h1 && ref_div_out_q
        |=> ##1 power_down_q)
        else $error("sync power-down not on second edge");

    chip_off_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        !chip_enable |=> power_down_q && !ref_buf_en_q)
        else $error("chip enable low did not disable");

    pd_effects_a: assert property (@(posedge mclk) disable iff (!rst_b)
        power_down_q |-> pump_hiz_q && !rf_bias_q && !ref_buf_en_q && (!ref_div_out_q || !$past(power_down_q)))
        else $error("power-down effects missing");

    latch_in_pd_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        power_down_q && wr_fb |=> main_count_q == $past(word[20:8]))
        else $error("latching stopped in power-down");

    gain_latest_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        wr_fb |=> pump_gain_select_q == $past(word[21]))
        else $error("gain not last written");

    lock_count_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        $rose(lock_q) |-> $past(ok_cnt_q) + 3'h1 >= $past(lock_need))
        else $error("lock declared early");

    band_hold_a: assert property (@(posedge mclk) disable iff (!rst_b || !clk_en)
        wr_fb |=> vtune_hold_q && band_cnt_q == 3'h5)
        else $error("band selection not started");
endmodule

// ---- pll_latch_programming_tb_top.sv ----
// Purpose: Self-checking bench for the latch bank
// Assumes: Host model drives the serial pins
// Notes:   Fixed seed; pulse counters watch the divider outputs
`timescale 1ns/1ps
`include "pll_consts.svh"
module pll_latch_programming_tb_top;
    logic        mclk, rst_b, clk_en, chip_enable, ref_tick, fb_tick, phase_small, phase_large;
    logic        sclk, sdata, load_enable, power_down_q, pump_hiz_q, pump_gain_select_q;
    logic        detector_polarity_q, ref_buf_en_q, rf_bias_q, lock_q, vtune_hold_q;
    logic        output_halving_q, prescaler_source_q, ref_div_out_q, fb_div_out_q, band_clk_q;
    logic [5:0]  prescaler_mod_q;
    logic [13:0] ref_ratio_q, r;
    logic [4:0]  swallow_count_q;
    logic [12:0] main_count_q;
    logic        g, h, p;
    int          error_cnt, total_checks, seed;
    int          n_ref, n_band, n_fb, nr, nb, nf;
    pll_host_model pll_host_model_i (.mclk, .sclk, .sdata, .load_enable);
    pll_latch_programming pll_latch_programming_i (.mclk, .rst_b, .clk_en, .sclk, .sdata,
        .load_enable, .chip_enable, .ref_tick, .fb_tick, .phase_small, .phase_large,
        .power_down_q, .pump_hiz_q, .pump_gain_select_q, .detector_polarity_q, .ref_buf_en_q,
        .rf_bias_q, .lock_q, .vtune_hold_q, .prescaler_mod_q, .output_halving_q,
        .prescaler_source_q, .ref_ratio_q, .swallow_count_q, .main_count_q, .ref_div_out_q,
        .fb_div_out_q, .band_clk_q);
    ////////////////////////////////////////////////////////////
    // Word builders; spare, test and unused bits kept at zero
    function automatic logic [23:0] cfg_w(logic [1:0] ps, logic md, en, mu, gn, hz, pl);
        return {ps, md, en, 8'h00, mu, gn, hz, pl, 8'h00};
    endfunction
    function automatic logic [23:0] ref_w(logic [1:0] bd, logic pr, logic [13:0] ra);
        return {2'b00, bd, 1'b0, pr, 2'b00, ra, 2'b01};
    endfunction
    function automatic logic [23:0] fb_w(logic sr, hv, gn, logic [12:0] mn, logic [4:0] sw);
        return {sr, hv, gn, mn, 1'b0, sw, 2'b10};
    endfunction
    function automatic logic [5:0] exp_mod(logic [1:0] c);
        return c == 2'b00 ? `PLL_MOD_8 : (c == 2'b01 ? `PLL_MOD_16 : `PLL_MOD_32);
    endfunction
    ////////////////////////////////////////////////////////////
    // Compare, write-and-settle, and reference pulse helpers
    task automatic chk(input logic [23:0] got, exp, input string m);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [23:0] w);
        pll_host_model_i.send_word(w);
        repeat (4) @(posedge mclk) #1; // Field lands two edges after load, pd three
    endtask
    task automatic ref_pulses(input int n);
        repeat (n) begin
            ref_tick = 1'b1;
            @(posedge mclk) #1;
            ref_tick = 1'b0;
            repeat (4) @(posedge mclk) #1;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Random feedback ticks keep the main counter busy
    always @(posedge mclk) fb_tick <= #1 1'($urandom);
    // Pulse counters; each one-cycle pulse is seen once at the following edge
    always @(posedge mclk) begin
        n_ref  <= n_ref + int'(ref_div_out_q);
        n_band <= n_band + int'(band_clk_q);
        n_fb   <= n_fb + int'(fb_div_out_q);
    end
    // Watchdog far beyond the expected 1,240 or so cycles
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {rst_b, clk_en, ref_tick, phase_small, phase_large, chip_enable} = 6'b010001;
        seed = $urandom(68697);
        repeat (20) @(posedge mclk) #1;
        chk(power_down_q, 1, "reset pd");
        chk(prescaler_mod_q, `PLL_MOD_8, "reset mod");
        rst_b = 1'b1;
        r = 14'(1 + $urandom % 16383);
        wr(ref_w(2'($urandom), 1'b0, r));
        chk(ref_ratio_q, r, "ref ratio");
        chk(power_down_q, 0, "run after reset");
        for (int c = 0; c < 4; c++) begin
            {g, h, p} = 3'($urandom);
            wr(cfg_w(2'(c), 1'b0, 1'b0, 1'b0, g, h, p));
            chk(prescaler_mod_q, exp_mod(2'(c)), "modulus");
            chk(pump_gain_select_q, g, "cfg gain");
            chk(pump_hiz_q, h, "three-state");
            chk(detector_polarity_q, p, "polarity");
        end
        // Frozen clock enable must swallow a whole word
        clk_en = 1'b0;
        wr(cfg_w(2'b11, 1'b0, 1'b0, 1'b0, g, h, !p));
        clk_en = 1'b1;
        chk(detector_polarity_q, p, "frozen by clk_en");
        $display("test config done");
        for (int k = 0; k < 2; k++) begin
            {h, p} = 2'($urandom);
            wr(fb_w(p, h, ~g, k ? 13'h1fff : 13'h0003, k ? 5'h1f : 5'h00));
            chk(main_count_q, k ? 13'h1fff : 13'h0003, "main count");
            chk(swallow_count_q, k ? 5'h1f : 5'h00, "swallow");
            chk({output_halving_q, prescaler_source_q}, {h, p}, "halve/source");
            chk(pump_gain_select_q, !g, "fb gain");
            chk(vtune_hold_q, 1, "band hold");
        end
        wr(24'hff00_03);
        chk(main_count_q, 13'h1fff, "test latch");
        chk(ref_ratio_q, r, "test latch ref");
        $display("test feedback done");
        wr(cfg_w(2'b00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        chk({power_down_q, pump_hiz_q, ref_buf_en_q, rf_bias_q}, 4'b1100, "async pd");
        wr(fb_w(1'b0, 1'b0, 1'b0, 13'h0003, 5'h07));
        chk(main_count_q, 13'h0003, "write in pd");
        wr(cfg_w(2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
        chip_enable = 1'b0;
        repeat (2) @(posedge mclk) #1;
        chk(power_down_q, 1, "chip enable");
        chip_enable = 1'b1;
        $display("test power-down done");
        wr(ref_w(2'b00, 1'b0, 14'h0001));
        wr(cfg_w(2'b00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        chk(rf_bias_q, 0, "muted");
        {phase_small, phase_large} = 2'b11;
        ref_pulses(3);
        chk({lock_q, vtune_hold_q}, 2'b01, "large error");
        phase_large = 1'b0;
        ref_pulses(2);
        chk({lock_q, vtune_hold_q}, 2'b00, "early lock");
        ref_pulses(1);
        chk({lock_q, rf_bias_q}, 2'b11, "lock unmute");
        // Counter clear freezes the dividers; main count 3 makes feedback pulses likely
        wr(cfg_w(2'b00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0) | 24'h0000_10);
        {nr, nb, nf} = {n_ref, n_band, n_fb};
        ref_pulses(6);
        chk(24'(n_ref - nr + n_band - nb + n_fb - nf), 0, "counter clear");
        wr(cfg_w(2'b00, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        wr(ref_w(2'b11, 1'b0, 14'h0003));
        {nr, nb} = {n_ref, n_band};
        ref_pulses(24);
        chk(24'(n_ref - nr), 8, "ratio 3");
        chk(24'(n_band - nb), 1, "band clock by 8");
        wr(ref_w(2'b00, 1'b0, 14'h0001));
        wr(cfg_w(2'b00, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
        ref_pulses(1);
        chk(power_down_q, 0, "sync wait");
        ref_pulses(1);
        chk({power_down_q, lock_q}, 2'b10, "sync pd");
        $display("test lock and sync done");
        give_verdict();
    end
endmodule

// ---- pll_pkg.sv ----
// Purpose: Types shared by the latch bank files
// Assumes: Nothing beyond the constants header
// Notes:   Power-down sequencing states
package pll_pkg;
    typedef enum logic [1:0] {
        PLL_PD_RUN  = 2'b00,
        PLL_PD_WAIT = 2'b01,
        PLL_PD_DOWN = 2'b10
    } pll_pd_e;
endpackage

// ---- pll_serial_in.sv ----
// Purpose: Three-wire serial shift register with load-enable transfer
// Assumes: Serial pins already synchronous to mclk
// Notes:   Keeps working during power-down
`timescale 1ns/1ps
`include "pll_consts.svh"
module pll_serial_in
    import pll_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire logic                   clk_en,
    input  wire logic                   sclk,
    input  wire logic                   sdata,
    input  wire logic                   load_enable,
    output logic [`PLL_WORD_W-1:0]      word_q,
    output logic                        word_valid_q
);
    logic                   sclk_q;
    logic                   le_q;
    logic [`PLL_WORD_W-1:0] shift_q;

    ////////////////////////////////////////////////////////////////////////
    // Edge history of the serial pins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 1'b0;
            le_q   <= 1'b0;
        end else if (clk_en) begin
            sclk_q <= sclk;
            le_q   <= load_enable;
        end
    end

    // MSB first shift on each rising serial clock
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= '0;
        end else if (clk_en && sclk && !sclk_q) begin
            shift_q <= {shift_q[`PLL_WORD_W-2:0], sdata};
        end
    end

    // Transfer on rising load enable, one-cycle valid
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            word_q       <= '0;
            word_valid_q <= 1'b0;
        end else if (clk_en) begin
            word_valid_q <= load_enable && !le_q;
            if (load_enable && !le_q) begin
                word_q <= shift_q;
            end
        end
    end
endmodule
